/* File: src/adcsq_top.sv */
// sample sequence control: triggers, sample/hold, results, flags
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module adcsq_top
    import adcsq_pkg::*;
#(
    parameter int FLAG_DELAY = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // trigger sources
    input wire logic [1:0] event_manager_triggers,
    input wire logic external_conversion_start,
    // digitised inputs
    input wire logic [CHAN_N-1:0][DATA_W-1:0] chan_code,
    // converter side
    output logic converter_clock,
    output logic sample_hold,
    output logic [DATA_W-1:0] result_a,
    output logic [DATA_W-1:0] result_b,
    output logic converter_flag_a,
    output logic converter_flag_b
);
    logic [ACQ_W-1:0] acq_q;
    logic sample_mode_select_q;
    logic [1:0] ref_pwr_q;
    logic core_pwr_q;
    logic [CHAN_W-1:0] chsel_q;
    logic cont_q, evt_en_q, ext_en_q;
    logic ext_prev_q;
    logic phase_q;
    adcsq_state_e st_q;
    logic [CNT_W-1:0] cnt_q;
    logic sh_q;
    logic [DATA_W-1:0] res_a_q, res_b_q, b_hold_q;
    logic [CONV_DIV-1:0] b_lag_q;
    logic [FLAG_DELAY-1:0] dly_a_q, dly_b_q;
    logic flag_a_q, flag_b_q;
    logic [31:0] rdata_q, rd_word;
    logic [CNT_W-1:0] sh_len_q;
    logic wr_ctrl1, wr_ctrl3, wr_chsel, wr_cmd, wr_stat;
    logic sw_trig, ext_rise, trig_go, hold_end;
    logic [CNT_W-1:0] hold_len, gap_len;
    logic [CHAN_W-1:0] sel_a, sel_b;
    adcsq_pipe_if pif ();

    // ********************************************************
    // register writes
    // ********************************************************
    assign wr_ctrl1 = reg_wr && (reg_addr == REG_CTRL1);
    assign wr_ctrl3 = reg_wr && (reg_addr == REG_CTRL3);
    assign wr_chsel = reg_wr && (reg_addr == REG_CHSEL);
    assign wr_cmd = reg_wr && (reg_addr == REG_CMD);
    assign wr_stat = reg_wr && (reg_addr == REG_STAT);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acq_q <= '0;
            sample_mode_select_q <= 1'b0;
            chsel_q <= '0;
            cont_q <= 1'b0;
            evt_en_q <= 1'b0;
            ext_en_q <= 1'b0;
        end else begin
            if (wr_ctrl1) begin
                acq_q <= reg_wdata[CTRL1_ACQ_LSB +: ACQ_W];
                sample_mode_select_q <= reg_wdata[CTRL1_SAMPLE_MODE_SELECT];
            end
            if (wr_chsel) begin
                chsel_q <= reg_wdata[CHAN_W-1:0];
            end
            if (wr_cmd) begin
                cont_q <= reg_wdata[CMD_CONT];
                evt_en_q <= reg_wdata[CMD_EVT_EN];
                ext_en_q <= reg_wdata[CMD_EXT_EN];
            end
        end
    end

    // no ordering check: sequencing the power bits is software's job
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ref_pwr_q <= '0;
            core_pwr_q <= 1'b0;
        end else if (wr_ctrl3) begin
            ref_pwr_q <= {reg_wdata[CTRL3_REF1],
                reg_wdata[CTRL3_REF0]};
            core_pwr_q <= reg_wdata[CTRL3_CORE];
        end
    end

    // ********************************************************
    // converter clock and triggers
    // ********************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
            ext_prev_q <= external_conversion_start;
        end
    end

    assign sw_trig = wr_cmd && reg_wdata[CMD_SW];
    assign ext_rise = external_conversion_start && !ext_prev_q;
    // a trigger during a running sequence is dropped, not queued
    assign trig_go = core_pwr_q && (sw_trig
        || (evt_en_q && (|event_manager_triggers))
        || (ext_en_q && ext_rise));

    // ********************************************************
    // sample/hold sequencer
    // ********************************************************
    assign hold_len = CNT_W'((32'(acq_q) + 32'd1) * CONV_DIV);
    assign gap_len = sample_mode_select_q ? SIM_GAP_HALF : SEQ_GAP_HALF;
    assign hold_end = core_pwr_q && (st_q == ST_HOLD) && (cnt_q == '0);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            sh_q <= 1'b0;
        end else if (!core_pwr_q) begin
            st_q <= ST_IDLE;
            sh_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (trig_go) begin
                        st_q <= ST_DELAY;
                        cnt_q <= TRIG_DLY_HALF - 6'h01;
                    end
                end
                ST_DELAY: begin
                    if (cnt_q == '0) begin
                        st_q <= ST_HOLD;
                        sh_q <= 1'b1;
                        cnt_q <= hold_len - 6'h01;
                    end else begin
                        cnt_q <= cnt_q - 6'h01;
                    end
                end
                ST_HOLD: begin
                    if (cnt_q == '0) begin
                        sh_q <= 1'b0;
                        if (cont_q) begin
                            st_q <= ST_GAP;
                            cnt_q <= gap_len - 6'h01;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q - 6'h01;
                    end
                end
                ST_GAP: begin
                    if (cnt_q == '0) begin
                        st_q <= ST_HOLD;
                        sh_q <= 1'b1;
                        cnt_q <= hold_len - 6'h01;
                    end else begin
                        cnt_q <= cnt_q - 6'h01;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // channel capture and pipeline
    // ********************************************************
    assign sel_a = sample_mode_select_q ? {1'b0, chsel_q[PAIR_W-1:0]} : chsel_q;
    assign sel_b = {1'b1, chsel_q[PAIR_W-1:0]};
    assign pif.cap = hold_end;
    assign pif.pair = sample_mode_select_q;
    assign pif.a = chan_code[sel_a];
    assign pif.b = chan_code[sel_b];

    adcsq_pipe u_pipe (
        .clock(clock),
        .rst(rst),
        .pif(pif)
    );

    // ********************************************************
    // results and flags
    // ********************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            res_a_q <= '0;
            res_b_q <= '0;
            b_hold_q <= '0;
            b_lag_q <= '0;
        end else begin
            // b leaves one converter clock after a
            b_lag_q <= {b_lag_q[CONV_DIV-2:0], pif.out_vld && pif.out_pair};
            if (pif.out_vld) begin
                res_a_q <= pif.out_a;
                b_hold_q <= pif.out_b;
            end
            if (b_lag_q[CONV_DIV-1]) begin
                res_b_q <= b_hold_q;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dly_a_q <= '0;
            dly_b_q <= '0;
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
        end else begin
            dly_a_q <= FLAG_DELAY'({dly_a_q, pif.out_vld});
            dly_b_q <= FLAG_DELAY'({dly_b_q, b_lag_q[CONV_DIV-1]});
            // a new event beats a clear in the same cycle
            flag_a_q <= dly_a_q[FLAG_DELAY-1]
                || (flag_a_q && !(wr_stat && reg_wdata[STAT_FA]));
            flag_b_q <= dly_b_q[FLAG_DELAY-1]
                || (flag_b_q && !(wr_stat && reg_wdata[STAT_FB]));
        end
    end

    // ********************************************************
    // register reads
    // ********************************************************
    always_comb begin
        rd_word = '0;
        case (reg_addr)
            REG_CTRL1: begin
                rd_word[CTRL1_ACQ_LSB +: ACQ_W] = acq_q;
                rd_word[CTRL1_SAMPLE_MODE_SELECT] = sample_mode_select_q;
            end
            REG_CTRL3: begin
                rd_word[CTRL3_REF1] = ref_pwr_q[1];
                rd_word[CTRL3_REF0] = ref_pwr_q[0];
                rd_word[CTRL3_CORE] = core_pwr_q;
            end
            REG_CHSEL: rd_word[CHAN_W-1:0] = chsel_q;
            REG_CMD: begin
                rd_word[CMD_CONT] = cont_q;
                rd_word[CMD_EVT_EN] = evt_en_q;
                rd_word[CMD_EXT_EN] = ext_en_q;
            end
            REG_STAT: begin
                rd_word[STAT_FA] = flag_a_q;
                rd_word[STAT_FB] = flag_b_q;
                rd_word[STAT_BUSY] = (st_q != ST_IDLE);
                rd_word[STAT_SH] = sh_q;
            end
            REG_RES_A: rd_word[DATA_W-1:0] = res_a_q;
            REG_RES_B: rd_word[DATA_W-1:0] = res_b_q;
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd ? rd_word : '0;
        end
    end

    assign reg_rdata = rdata_q;
    assign converter_clock = phase_q;
    assign sample_hold = sh_q;
    assign result_a = res_a_q;
    assign result_b = res_b_q;
    assign converter_flag_a = flag_a_q;
    assign converter_flag_b = flag_b_q;

    // ********************************************************
    // checks
    // ********************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sh_len_q <= '0;
        end else begin
            sh_len_q <= sh_q ? sh_len_q + 6'h01 : '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_trig_wait;
        !sh_q [*5];
    endsequence
    sequence s_seq_gap;
        !sh_q ##1 sh_q;
    endsequence
    sequence s_sim_gap;
        !sh_q [*3] ##1 sh_q;
    endsequence

    property p_trig_to_sh;
        disable iff (rst || !core_pwr_q)
        (st_q == ST_IDLE && trig_go) |=> s_trig_wait ##1 sh_q;
    endproperty
    a_trig_to_sh: assert property (p_trig_to_sh)
        else $error("sample start not 2.5 clocks after trigger");

    property p_sh_width;
        disable iff (rst || !core_pwr_q)
        $fell(sh_q) |-> sh_len_q == $past(hold_len);
    endproperty
    a_sh_width: assert property (p_sh_width)
        else $error("sample/hold width wrong");

    property p_cap_fall;
        hold_end |=> $fell(sh_q);
    endproperty
    a_cap_fall: assert property (p_cap_fall)
        else $error("capture not at sample/hold fall");

    property p_first_a;
        disable iff (rst || !core_pwr_q)
        hold_end |-> ##9 (dly_a_q[0] && res_a_q == $past(pif.a, 9));
    endproperty
    a_first_a: assert property (p_first_a)
        else $error("first result late or wrong");

    property p_first_b;
        (hold_end && sample_mode_select_q) |-> ##11 (dly_b_q[0]
            && res_b_q == $past(pif.b, 11));
    endproperty
    a_first_b: assert property (p_first_b)
        else $error("second pair result late or wrong");

    property p_flag_delay;
        dly_a_q[0] |-> ##FLAG_DELAY flag_a_q;
    endproperty
    a_flag_delay: assert property (p_flag_delay)
        else $error("flag not set after result update");

    property p_unpowered;
        !core_pwr_q |=> (st_q == ST_IDLE && !sh_q);
    endproperty
    a_unpowered: assert property (p_unpowered)
        else $error("sequencer active without core power");

    property p_pwr_clear;
        (wr_ctrl3 && reg_wdata[CTRL3_REF1:CTRL3_CORE] == 3'h0)
            |=> (!core_pwr_q && ref_pwr_q == 2'h0);
    endproperty
    a_pwr_clear: assert property (p_pwr_clear)
        else $error("power bits not cleared together");

    property p_seq_period;
        disable iff (rst || !core_pwr_q)
        ($fell(sh_q) && cont_q && !sample_mode_select_q) |=> s_seq_gap;
    endproperty
    a_seq_period: assert property (p_seq_period)
        else $error("single mode repeat period wrong");

    property p_sim_period;
        disable iff (rst || !core_pwr_q)
        ($fell(sh_q) && cont_q && sample_mode_select_q) |=> s_sim_gap;
    endproperty
    a_sim_period: assert property (p_sim_period)
        else $error("pair mode repeat period wrong");
endmodule

/* File: include/adcsq_pkg.sv */
// shared constants and types of the sample sequence control block
package adcsq_pkg;
    // ********************************************************
    // widths
    // ********************************************************
    localparam int DATA_W = 12;
    localparam int CHAN_N = 16;
    localparam int CHAN_W = 4;
    localparam int PAIR_W = 3;
    localparam int ACQ_W = 4;
    localparam int ADDR_W = 5;
    localparam int CNT_W = 6;
    // ********************************************************
    // timing, counted in half converter clocks
    // ********************************************************
    // converter clock is the system clock divided by two
    localparam int CONV_DIV = 2;
    localparam int PIPE_STAGES = 4;
    localparam int PIPE_DEPTH = PIPE_STAGES * CONV_DIV;
    localparam logic [CNT_W-1:0] TRIG_DLY_HALF = 6'h05;
    localparam logic [CNT_W-1:0] SEQ_GAP_HALF = 6'h02;
    localparam logic [CNT_W-1:0] SIM_GAP_HALF = 6'h04;
    // ********************************************************
    // register byte offsets
    // ********************************************************
    localparam logic [ADDR_W-1:0] REG_CTRL1 = 5'h00;
    localparam logic [ADDR_W-1:0] REG_CTRL3 = 5'h04;
    localparam logic [ADDR_W-1:0] REG_CHSEL = 5'h08;
    localparam logic [ADDR_W-1:0] REG_CMD = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_STAT = 5'h10;
    localparam logic [ADDR_W-1:0] REG_RES_A = 5'h14;
    localparam logic [ADDR_W-1:0] REG_RES_B = 5'h18;
    // ********************************************************
    // field positions
    // ********************************************************
    localparam int CTRL1_ACQ_LSB = 8;
    localparam int CTRL1_SAMPLE_MODE_SELECT = 4;
    localparam int CTRL3_REF1 = 7;
    localparam int CTRL3_REF0 = 6;
    localparam int CTRL3_CORE = 5;
    localparam int CMD_SW = 0;
    localparam int CMD_CONT = 1;
    localparam int CMD_EVT_EN = 2;
    localparam int CMD_EXT_EN = 3;
    localparam int STAT_FA = 0;
    localparam int STAT_FB = 1;
    localparam int STAT_BUSY = 8;
    localparam int STAT_SH = 9;
    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DELAY,
        ST_HOLD,
        ST_GAP
    } adcsq_state_e;
endpackage

/* File: include/adcsq_pipe_if.sv */
// link between the sequencer and the conversion pipeline
`timescale 1ns/10ps
interface adcsq_pipe_if;
    logic cap;
    logic pair;
    logic [adcsq_pkg::DATA_W-1:0] a;
    logic [adcsq_pkg::DATA_W-1:0] b;
    logic out_vld;
    logic out_pair;
    logic [adcsq_pkg::DATA_W-1:0] out_a;
    logic [adcsq_pkg::DATA_W-1:0] out_b;
    modport ctrl (output cap, pair, a, b,
                  input out_vld, out_pair, out_a, out_b);
    modport pipe (input cap, pair, a, b,
                  output out_vld, out_pair, out_a, out_b);
endinterface

/* File: src/adcsq_pipe.sv */
// four-stage conversion pipeline, two slots per converter clock
`timescale 1ns/10ps
module adcsq_pipe
    import adcsq_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // sequencer side
    adcsq_pipe_if.pipe pif
);
    logic vld_q [PIPE_DEPTH];
    logic pair_q [PIPE_DEPTH];
    logic [DATA_W-1:0] a_q [PIPE_DEPTH];
    logic [DATA_W-1:0] b_q [PIPE_DEPTH];

    // ********************************************************
    // stages
    // ********************************************************
    for (genvar k = 0; k < PIPE_DEPTH; k++) begin : g_stage
        logic vld_in, pair_in;
        logic [DATA_W-1:0] a_in, b_in;
        // head stage takes the capture; no index below zero is built
        if (k == 0) begin : g_head
            assign vld_in = pif.cap;
            assign pair_in = pif.pair;
            assign a_in = pif.a;
            assign b_in = pif.b;
        end else begin : g_next
            assign vld_in = vld_q[k-1];
            assign pair_in = pair_q[k-1];
            assign a_in = a_q[k-1];
            assign b_in = b_q[k-1];
        end
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                vld_q[k] <= 1'b0;
                pair_q[k] <= 1'b0;
                a_q[k] <= '0;
                b_q[k] <= '0;
            end else begin
                vld_q[k] <= vld_in;
                pair_q[k] <= pair_in;
                a_q[k] <= a_in;
                b_q[k] <= b_in;
            end
        end
    end

    assign pif.out_vld = vld_q[PIPE_DEPTH-1];
    assign pif.out_pair = pair_q[PIPE_DEPTH-1];
    assign pif.out_a = a_q[PIPE_DEPTH-1];
    assign pif.out_b = b_q[PIPE_DEPTH-1];
endmodule

/* File: test/adcsq_far_model.sv */
// far side model: trigger sources and digitised channel codes
`timescale 1ns/10ps
module adcsq_far_model
    import adcsq_pkg::*;
(
    // clock
    input wire logic clock,
    // bench commands
    input wire logic go,
    input wire logic [1:0] src,
    input wire logic [7:0] base,
    // device side
    output logic [1:0] event_manager_triggers,
    output logic external_conversion_start,
    output logic [CHAN_N-1:0][DATA_W-1:0] chan_code
);
    initial begin
        event_manager_triggers = 2'h0;
        external_conversion_start = 1'b0;
    end
    // one-cycle pulses; pin idles low so every pulse is a fresh edge
    always @(posedge clock) begin
        event_manager_triggers <= (go && src == 2'h1)
            ? {base[0], ~base[0]} : 2'h0;
        external_conversion_start <= go && src == 2'h2;
    end
    // code carries its own channel number, so a wrong pick shows
    for (genvar i = 0; i < CHAN_N; i++) begin : g_ch
        assign chan_code[i] = {base, 4'(i)};
    end
endmodule

/* File: test/tb_adcsq_top.sv */
// self-checking bench of the sample sequence control block
`timescale 1ns/10ps
module tb_adcsq_top
    import adcsq_pkg::*;
;
    localparam int FD = 2;
    // shortened: the block does not time the references
    localparam int REF_WAIT = 2000;
    logic clock, rst, reg_wr, reg_rd, go, ext, cclk, sh, fa, fb;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_q, cmd_q;
    logic [1:0] src, evt;
    logic [7:0] base;
    logic [DATA_W-1:0] res_a, res_b;
    logic [CHAN_N-1:0][DATA_W-1:0] chan;
    logic sh_p, fa_p, fb_p, ext_p;
    int n_mismatch, n_tests, cyc, t0, t_rise, t_fall, t_fall2;
    int t_fa, t_fb, n_rise, armed;

    adcsq_top #(.FLAG_DELAY(FD)) uut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .event_manager_triggers(evt),
        .external_conversion_start(ext), .chan_code(chan),
        .converter_clock(cclk), .sample_hold(sh), .result_a(res_a),
        .result_b(res_b), .converter_flag_a(fa), .converter_flag_b(fb)
    );
    adcsq_far_model far (
        .clock(clock), .go(go), .src(src), .base(base),
        .event_manager_triggers(evt), .external_conversion_start(ext),
        .chan_code(chan)
    );

    // ****************************************
    // monitor: edge numbers of triggers and outputs
    // ****************************************
    always @(posedge clock) begin
        cyc <= cyc + 1;
        sh_p <= sh;
        fa_p <= fa;
        fb_p <= fb;
        ext_p <= ext;
        if (armed != 0 && ((reg_wr && reg_addr === REG_CMD
                && reg_wdata[CMD_SW]) || (cmd_q[CMD_EVT_EN] && |evt)
                || (cmd_q[CMD_EXT_EN] && ext && !ext_p))) begin
            t0 <= cyc;
            armed <= 0;
        end
        if (sh && !sh_p) begin
            n_rise <= n_rise + 1;
            t_rise <= cyc;
        end
        if (!sh && sh_p) begin
            t_fall2 <= t_fall;
            t_fall <= cyc;
        end
        if (fa && !fa_p) t_fa <= cyc;
        if (fb && !fb_p) t_fb <= cyc;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // code that the far side shows on a channel
    function automatic logic [DATA_W-1:0] exp_code(input logic [7:0] b,
            input int ch);
        return {b, 4'(ch)};
    endfunction

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        rd_q = reg_rdata;
    endtask

    task automatic power_up();
        wr(REG_CTRL3, 32'h000000C0);
        repeat (REF_WAIT) @(posedge clock);
        wr(REG_CTRL3, 32'h000000E0);
        repeat (500) @(posedge clock);
    endtask

    task automatic run(input bit pm, input int acq, input int ch,
            input int s, input bit cont);
        logic [7:0] b;
        logic [DATA_W-1:0] ea, eb;
        b = 8'($urandom);
        ch = pm ? ch % 8 : ch;
        ea = exp_code(b, ch);
        eb = exp_code(b, ch + 8);
        base <= b;
        wr(REG_CTRL1, (acq << CTRL1_ACQ_LSB) | (pm << CTRL1_SAMPLE_MODE_SELECT));
        wr(REG_CHSEL, 32'(ch));
        wr(REG_STAT, 32'h3);
        cmd_q = 32'h0000000C | (cont << CMD_CONT);
        wr(REG_CMD, cmd_q);
        t_rise = -1;
        t_fall = -1;
        t_fa = -1;
        t_fb = -1;
        n_rise = 0;
        armed = 1;
        if (s == 0) begin
            wr(REG_CMD, cmd_q | 32'h1);
        end else begin
            @(posedge clock);
            go <= 1'b1;
            src <= 2'(s);
            @(posedge clock);
            go <= 1'b0;
        end
        for (int i = 0; i < 300; i++) begin
            @(posedge clock);
            if (t_fa >= 0 && (!pm || t_fb >= 0) && (!cont || n_rise > 2))
                break;
        end
        if (cont) begin
            // continuous: fall to fall spacing is the result period
            check("period", 2 * (acq + (pm ? 3 : 2)),
                t_fall - t_fall2);
            rd(REG_STAT);
            check("busy", 1, rd_q[STAT_BUSY]);
            off();
        end else begin
            check("delay", TRIG_DLY_HALF + 1, t_rise - t0);
            check("width", 2 * (1 + acq), t_fall - t_rise);
            check("flag a", PIPE_DEPTH + FD,
                t_fa - t_fall);
            check("result a", ea, res_a);
            rd(REG_RES_A);
            check("reg result a", ea, rd_q);
            rd(REG_STAT);
            check("status", {2'b00, pm, 1'b1},
                {rd_q[STAT_SH], rd_q[STAT_BUSY], rd_q[1:0]});
            if (pm) begin
                check("flag b", PIPE_DEPTH + 2 + FD, t_fb - t_fall);
                check("result b", eb, res_b);
            end
        end
        $display("test done mode %0d acq %0d ch %0d src %0d", pm, acq, ch, s);
    endtask

    task automatic off();
        wr(REG_CTRL3, 32'h0);
        // the sequencer sees the cleared bit one edge after the write
        @(posedge clock);
        @(negedge clock);
        check("abort", 0, sh);
        repeat (40) @(posedge clock);
        wr(REG_STAT, 32'h3);
        n_rise = 0;
        wr(REG_CMD, 32'h1);
        repeat (60) @(posedge clock);
        check("unpowered rises", 0, n_rise);
        rd(REG_STAT);
        check("unpowered flags", 0, rd_q[1:0]);
        rd(5'h1C);
        check("unmapped", 0, rd_q);
        power_up();
    endtask

    task automatic print_verdict();
        $display("counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************
    // clock, watchdog, sequence
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // runs take some 9000 cycles; cut off at 40000
    initial begin
        #1600000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, go, src, base, reg_addr, reg_wdata} = '0;
        {cmd_q, cyc, armed, n_rise, n_mismatch, n_tests} = '0;
        void'($urandom(32'h1886F909));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check("reset", 0, {sh, fa, fb, cclk, res_a, res_b});
        @(negedge clock);
        check("converter clock", 1, cclk);
        power_up();
        // corner cases: extreme widths, last channel, last pair
        run(0, 0, 0, 0, 0);
        run(0, 15, 15, 1, 0);
        run(1, 0, 7, 2, 0);
        run(1, 15, 0, 0, 0);
        run(0, 3, 9, 2, 1);
        run(1, 2, 5, 1, 1);
        for (int i = 0; i < 12; i++)
            run(1'($urandom), $urandom % 16, $urandom % 16, $urandom % 3, 0);
        print_verdict();
    end
endmodule
